// *** hdl/wkhs_wakeup.sv ***
`timescale 1ns/1ps
module wkhs_wakeup
	import wkhs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rc_osc_in,
	input  wire logic        xtal_clk_in,
	input  wire logic        rf_energy_in,
	input  wire logic        supply_above_brownout,
	input  wire logic        supply_above_release,
	input  wire logic        serial_clock_line_in,
	output logic             serial_clock_line_out,
	output logic             serial_clock_line_oe,
	input  wire logic        serial_data_line_in,
	output logic             serial_data_line_out,
	output logic             serial_data_line_oe,
	output logic             data_alert_n,
	output logic             clock_output_pin,
	output logic             xtal_enable,
	output logic             rf_enable,
	output logic             irq
);
	logic [6:0]      async_in;
	logic [6:0]      meta;
	logic [6:0]      sync;
	logic [6:0]      sync_d;
	logic            rc_s;
	logic            rc_rise;
	logic            xtal_s;
	logic            rf_s;
	logic            scl_s;
	logic            sda_s;
	logic            scl_rise;
	logic            scl_fall;
	logic            ser_start;
	logic            ser_stop;
	logic            power_ok;
	logic            hold;
	logic [7:0]      regs [REG_COUNT];
	logic [3:0]      irq_status;
	logic [3:0]      irq_set;
	logic [3:0]      irq_clr;
	wkhs_wake_type   wstate;
	logic [1:0]      src;
	logic [7:0]      div_cnt;
	logic [7:0]      ivl_cnt;
	logic [7:0]      dly_cnt;
	logic            wake_tick;
	logic            timer_due;
	logic            sleep_req;
	wkhs_pins_type   pins;
	wkhs_pins_type   next_pins;
	wkhs_serial_type sstate;
	logic [3:0]      bit_cnt;
	logic [7:0]      sh;
	logic [7:0]      tx;
	logic [7:0]      ptr;
	logic            rnw;
	logic            ser_low;
	logic            ser_we;
	logic [7:0]      ser_wdata;
	logic [7:0]      ser_rdata;
	logic [4:0]      apb_idx;
	logic            apb_ok;
	logic            apb_acc;
	logic            apb_we;
	logic            ack_q;
	logic            err_q;

	function automatic logic [7:0] rd_mux(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == {3'h0, IDX_IRQ_STATUS}) begin
			v = {4'h0, irq_status};
		end else if (idx == {3'h0, IDX_STATE}) begin
			v = {2'h0, src, wstate};
		end else if (idx < 8'(REG_COUNT)) begin
			v = regs[idx[4:0]];
		end
		return v;
	endfunction

	// every pin and the second clock pass two flops before use
	assign async_in = {serial_data_line_in, serial_clock_line_in,
		supply_above_release, supply_above_brownout,
		rf_energy_in, xtal_clk_in, rc_osc_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta   <= SYNC_RESET;
			sync   <= SYNC_RESET;
			sync_d <= SYNC_RESET;
		end else begin
			meta   <= async_in;
			sync   <= meta;
			sync_d <= sync;
		end
	end

	assign rc_s     = sync[0];
	assign xtal_s   = sync[1];
	assign rf_s     = sync[2];
	assign scl_s    = sync[5];
	assign sda_s    = sync[6];
	assign rc_rise  = sync[0] & ~sync_d[0];
	assign scl_rise = scl_s & ~sync_d[5];
	assign scl_fall = ~scl_s & sync_d[5];
	// start and stop are data edges while the clock line stays high
	assign ser_start = scl_s & sync_d[5] & sync_d[6] & ~sda_s;
	assign ser_stop  = scl_s & sync_d[5] & ~sync_d[6] & sda_s;

	// hysteresis: drop below brownout, rise only past the release level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_ok <= 1'b0;
		end else if (!sync[3]) begin
			power_ok <= 1'b0;
		end else if (sync[4]) begin
			power_ok <= 1'b1;
		end
	end

	assign hold = ~power_ok;

	// apb: one wait state so that read data comes from a flop
	assign apb_idx = paddr[6:2];
	assign apb_ok  = (paddr[1:0] == 2'h0) && !paddr[7] && (apb_idx < 5'(REG_COUNT));
	assign apb_acc = psel & penable;
	assign apb_we  = apb_acc & ack_q & pwrite & apb_ok;
	assign pready  = ack_q;
	assign pslverr = ack_q & err_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q  <= 1'b0;
			err_q  <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			ack_q <= apb_acc & ~ack_q;
			if (apb_acc && !ack_q) begin
				err_q  <= ~apb_ok;
				prdata <= apb_ok ? {24'h00_0000, rd_mux({3'h0, apb_idx})} : 32'h0000_0000;
			end
		end
	end

	// register file; the bus wins a same-cycle clash with a serial write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= REG_RESET;
			end
		end else if (hold) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= REG_RESET;
			end
		end else if (apb_we) begin
			regs[apb_idx] <= pwdata[7:0];
		end else if (ser_we && ptr < 8'(REG_COUNT)) begin
			regs[ptr[4:0]] <= ser_wdata;
		end
	end

	assign sleep_req = (apb_we && apb_idx == IDX_CTRL && pwdata[CTRL_SLEEP])
		|| (!apb_we && ser_we && ptr == {3'h0, IDX_CTRL} && ser_wdata[CTRL_SLEEP]);

	// sticky events, write one to clear; a new event beats the clear
	always_comb begin
		irq_set = 4'h0;
		irq_clr = 4'h0;
		if (wstate == W_SLEEP && rf_s) begin
			irq_set[IRQ_RF] = 1'b1;
		end else if (wstate == W_SLEEP && !scl_s && !sda_s) begin
			irq_set[IRQ_EXT] = 1'b1;
		end
		if (wstate == W_DELAY && dly_cnt == regs[IDX_ALERT_DLY]) begin
			irq_set[IRQ_TIMER] = 1'b1;
		end
		irq_set[IRQ_SERIAL] = ser_we;
		if (apb_we && apb_idx == IDX_IRQ_STATUS) begin
			irq_clr = pwdata[3:0];
		end else if (ser_we && ptr == {3'h0, IDX_IRQ_STATUS}) begin
			irq_clr = ser_wdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 4'h0;
			irq        <= 1'b0;
		end else if (hold) begin
			irq_status <= 4'h0;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			irq        <= |(irq_status & regs[IDX_IRQ_MASK][3:0]);
		end
	end

	// a zero divider or count behaves as one
	assign wake_tick = (wstate == W_SLEEP) && rc_rise
		&& ({1'b0, div_cnt} + 9'h001 >= {1'b0, regs[IDX_WAKE_DIV]});
	assign timer_due = wake_tick
		&& ({1'b0, ivl_cnt} + 9'h001 >= {1'b0, regs[IDX_WAKE_IVL]});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
			ivl_cnt <= 8'h00;
		end else if (wstate != W_SLEEP) begin
			div_cnt <= 8'h00;
			ivl_cnt <= 8'h00;
		end else if (wake_tick) begin
			div_cnt <= 8'h00;
			ivl_cnt <= ivl_cnt + 8'h01;
		end else if (rc_rise) begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wstate  <= W_AWAKE;
			src     <= SRC_NONE;
			dly_cnt <= 8'h00;
		end else if (hold) begin
			wstate  <= W_AWAKE;
			src     <= SRC_NONE;
			dly_cnt <= 8'h00;
		end else begin
			case (wstate)
				W_AWAKE: begin
					if (sleep_req) begin
						wstate <= W_SLEEP;
						src    <= SRC_NONE;
					end
				end
				W_SLEEP: begin
					dly_cnt <= 8'h00;
					if (rf_s) begin
						wstate <= W_IND;
						src    <= SRC_RF;
					end else if (!scl_s && !sda_s) begin
						wstate <= W_IND;
						src    <= SRC_EXT;
					end else if (timer_due) begin
						wstate <= W_DELAY;
					end
				end
				W_DELAY: begin
					// delay counts periods of the RC clock now on the output
					if (dly_cnt == regs[IDX_ALERT_DLY]) begin
						wstate <= W_IND;
						src    <= SRC_TIMER;
					end else if (rc_rise) begin
						dly_cnt <= dly_cnt + 8'h01;
					end
				end
				W_IND: begin
					// timer wake pulls data low itself, which looks like a start;
					// only a falling clock may end that indication
					if ((ser_start && src != SRC_TIMER) || scl_fall) begin
						wstate <= W_AWAKE;
					end
				end
				default: begin
					wstate <= W_AWAKE;
				end
			endcase
		end
	end

	always_comb begin
		next_pins.alert_n = 1'b1;
		next_pins.sda_oe  = ser_low;
		next_pins.clk_out = xtal_s;
		next_pins.xtal_en = 1'b1;
		next_pins.rf_en   = 1'b1;
		case (wstate)
			W_SLEEP: begin
				next_pins.sda_oe  = 1'b0;
				next_pins.clk_out = 1'b0;
				next_pins.xtal_en = 1'b0;
				next_pins.rf_en   = 1'b0;
			end
			W_DELAY: begin
				next_pins.sda_oe  = 1'b0;
				next_pins.clk_out = rc_s;
				next_pins.xtal_en = 1'b0;
				next_pins.rf_en   = 1'b0;
			end
			W_IND: begin
				if (src == SRC_RF) begin
					next_pins.alert_n = 1'b0;
					next_pins.sda_oe  = 1'b0;
				end else if (src == SRC_TIMER) begin
					next_pins.alert_n = 1'b0;
					next_pins.sda_oe  = 1'b1;
					next_pins.clk_out = rc_s;
					next_pins.xtal_en = 1'b0;
				end else begin
					next_pins.sda_oe = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '{alert_n: 1'b1, default: 1'b0};
		end else begin
			pins <= next_pins;
		end
	end

	assign data_alert_n          = pins.alert_n;
	assign serial_data_line_oe   = pins.sda_oe;
	assign serial_data_line_out  = 1'b0;
	assign clock_output_pin      = pins.clk_out;
	assign xtal_enable           = pins.xtal_en;
	assign rf_enable             = pins.rf_en;
	assign serial_clock_line_out = 1'b0;
	assign serial_clock_line_oe  = 1'b0;

	// a process, not an assign, so that register writes also refresh it
	always_comb begin
		ser_rdata = rd_mux(ptr);
	end

	// serial slave: sample on rising clock, change data on falling clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sstate    <= S_IDLE;
			bit_cnt   <= 4'h0;
			sh        <= 8'h00;
			tx        <= 8'h00;
			ptr       <= 8'h00;
			rnw       <= 1'b0;
			ser_low   <= 1'b0;
			ser_we    <= 1'b0;
			ser_wdata <= 8'h00;
		end else begin
			ser_we <= 1'b0;
			if (hold || ser_stop || wstate == W_SLEEP) begin
				sstate  <= S_IDLE;
				ser_low <= 1'b0;
			end else if (ser_start) begin
				sstate  <= S_ADDR;
				bit_cnt <= 4'h0;
				ser_low <= 1'b0;
			end else if (scl_rise) begin
				case (sstate)
					S_ADDR, S_PTR, S_WDATA: begin
						sh      <= {sh[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					S_RDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					S_RACK: begin
						if (sda_s) begin
							sstate <= S_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (sstate)
					S_ADDR: begin
						if (bit_cnt == 4'h8) begin
							if (sh[7:1] == SERIAL_ADDR_WR[7:1]) begin
								sstate  <= S_ACK_A;
								rnw     <= sh[0];
								ser_low <= 1'b1;
							end else begin
								sstate <= S_IDLE;
							end
						end
					end
					S_PTR: begin
						if (bit_cnt == 4'h8) begin
							ptr     <= sh;
							sstate  <= S_ACK_P;
							ser_low <= 1'b1;
						end
					end
					S_WDATA: begin
						if (bit_cnt == 4'h8) begin
							ser_we    <= 1'b1;
							ser_wdata <= sh;
							sstate    <= S_ACK_W;
							ser_low   <= 1'b1;
						end
					end
					S_ACK_A: begin
						bit_cnt <= 4'h0;
						if (rnw) begin
							sstate  <= S_RDATA;
							tx      <= ser_rdata;
							ser_low <= ~ser_rdata[7];
						end else begin
							sstate  <= S_PTR;
							ser_low <= 1'b0;
						end
					end
					S_ACK_P, S_ACK_W: begin
						if (sstate == S_ACK_W) begin
							ptr <= ptr + 8'h01;
						end
						bit_cnt <= 4'h0;
						sstate  <= S_WDATA;
						ser_low <= 1'b0;
					end
					S_RDATA: begin
						if (bit_cnt == 4'h8) begin
							sstate  <= S_RACK;
							ptr     <= ptr + 8'h01;
							ser_low <= 1'b0;
						end else begin
							tx      <= {tx[6:0], 1'b0};
							ser_low <= ~tx[6];
						end
					end
					S_RACK: begin
						bit_cnt <= 4'h0;
						sstate  <= S_RDATA;
						tx      <= ser_rdata;
						ser_low <= ~ser_rdata[7];
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

// *** hdl/wkhs_pkg.sv ***
package wkhs_pkg;
	localparam int         REG_COUNT      = 31;
	localparam logic [4:0] IDX_WAKE_DIV   = 5'h14;
	localparam logic [4:0] IDX_WAKE_IVL   = 5'h15;
	localparam logic [4:0] IDX_ALERT_DLY  = 5'h17;
	localparam logic [4:0] IDX_CTRL       = 5'h18;
	localparam logic [4:0] IDX_IRQ_STATUS = 5'h19;
	localparam logic [4:0] IDX_IRQ_MASK   = 5'h1A;
	localparam logic [4:0] IDX_STATE      = 5'h1B;
	localparam int         CTRL_SLEEP     = 0;
	localparam int         IRQ_RF         = 0;
	localparam int         IRQ_TIMER      = 1;
	localparam int         IRQ_EXT        = 2;
	localparam int         IRQ_SERIAL     = 3;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] SERIAL_ADDR_WR = 8'h68;
	localparam int         RC_FREQ_HZ     = 10000;
	localparam int         SERIAL_MAX_BPS = 400000;
	// sync bit order: sda, scl, release, brownout, rf, xtal, rc
	localparam logic [6:0] SYNC_RESET     = 7'h60;
	localparam logic [1:0] SRC_NONE       = 2'h0;
	localparam logic [1:0] SRC_RF         = 2'h1;
	localparam logic [1:0] SRC_TIMER      = 2'h2;
	localparam logic [1:0] SRC_EXT        = 2'h3;
	typedef enum logic [3:0] {
		W_AWAKE = 4'h1,
		W_SLEEP = 4'h2,
		W_DELAY = 4'h4,
		W_IND   = 4'h8
	} wkhs_wake_type;
	typedef enum logic [8:0] {
		S_IDLE  = 9'h001,
		S_ADDR  = 9'h002,
		S_ACK_A = 9'h004,
		S_PTR   = 9'h008,
		S_ACK_P = 9'h010,
		S_WDATA = 9'h020,
		S_ACK_W = 9'h040,
		S_RDATA = 9'h080,
		S_RACK  = 9'h100
	} wkhs_serial_type;
	typedef struct packed {
		logic alert_n;
		logic sda_oe;
		logic clk_out;
		logic xtal_en;
		logic rf_en;
	} wkhs_pins_type;
endpackage

// *** tb/wkhs_wakeup_props.sv ***
`timescale 1ns/1ps
module wkhs_wakeup_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        supply_above_brownout,
	input wire logic        serial_clock_line_in,
	input wire logic        serial_clock_line_oe,
	input wire logic        serial_data_line_in,
	input wire logic        serial_data_line_oe,
	input wire logic        data_alert_n,
	input wire logic        xtal_enable,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no ready in access cycle");
	a_pready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_bad_index: assert property (
		psel && penable && !pready && paddr[7:2] >= 6'd31 |=> pslverr)
		else $error("index past register space accepted");
	a_scl_passive: assert property (!serial_clock_line_oe)
		else $error("slave drove serial clock");
	a_alert_release: assert property (
		!data_alert_n && $fell(serial_clock_line_in) |-> ##[1:8] data_alert_n)
		else $error("wake indication not released");
	a_rf_xtal: assert property (
		!data_alert_n && $stable(data_alert_n) && !serial_data_line_oe |-> xtal_enable)
		else $error("rf wake without crystal");
	a_ext_alert: assert property (
		!serial_clock_line_in && !serial_data_line_in && !serial_data_line_oe
		&& data_alert_n |=> data_alert_n)
		else $error("alert on controller wake");
	a_brown_quiet: assert property (
		!supply_above_brownout [*8] |-> data_alert_n && !serial_data_line_oe && !irq)
		else $error("activity in brownout");
endmodule

// *** tb/wkhs_master.sv ***
`timescale 1ns/1ps
module wkhs_master (
	input  wire logic pclk,
	input  wire logic sda,
	output logic      scl_oe,
	output logic      sda_oe
);
	// quarter bit of 64 cycles keeps the rate just under 400 kbit/s
	localparam int QTR = 64;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic wt();
		repeat (QTR) @(posedge pclk);
	endtask
	// also a repeated start; leaves both lines low
	task automatic start();
		sda_oe <= 1'b0;
		wt();
		scl_oe <= 1'b0;
		wt();
		sda_oe <= 1'b1;
		wt();
		scl_oe <= 1'b1;
		wt();
	endtask
	task automatic stop();
		sda_oe <= 1'b1;
		wt();
		scl_oe <= 1'b0;
		wt();
		sda_oe <= 1'b0;
		wt();
	endtask
	task automatic xbit(input logic v, output logic r);
		sda_oe <= !v;
		wt();
		scl_oe <= 1'b0;
		wt();
		r = sda;
		wt();
		scl_oe <= 1'b1;
		wt();
	endtask
	// ab is the master's own acknowledge bit, low to acknowledge a read
	task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r);
			q[i] = r;
		end
		xbit(ab, r);
		ack = !r;
	endtask
	task automatic wake_req();
		scl_oe <= 1'b1;
		sda_oe <= 1'b1;
		repeat (4) wt();
	endtask
endmodule

// *** tb/wkhs_wakeup_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("FAIL %0t mismatch got %h want %h", $time, g, e); end end
module wkhs_wakeup_test
	import wkhs_pkg::*;
;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	logic        pclk, presetn, psel, penable, pwrite, rc, xt, rf, brn, rel;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, e, ack, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
	logic        alert_n, clk_o, xen, rfen, irq;
	wire         scl = !(scl_oe | m_scl);
	wire         sda = !(sda_oe | m_sda);
	initial begin
		{pclk, presetn, psel, penable, pwrite, rc, xt, rf} = 8'h00;
		{brn, rel} = 2'b11;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	always #5 pclk = ~pclk;
	// fast stand-in for the slow oscillator keeps the run short
	always #200 rc = ~rc;
	always #50 xt = ~xt;
	wkhs_wakeup dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rc_osc_in(rc), .xtal_clk_in(xt), .rf_energy_in(rf),
		.supply_above_brownout(brn), .supply_above_release(rel),
		.serial_clock_line_in(scl), .serial_clock_line_out(scl_o),
		.serial_clock_line_oe(scl_oe), .serial_data_line_in(sda),
		.serial_data_line_out(sda_o), .serial_data_line_oe(sda_oe),
		.data_alert_n(alert_n), .clock_output_pin(clk_o), .xtal_enable(xen),
		.rf_enable(rfen), .irq(irq));
	wkhs_master m (.pclk(pclk), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
	task automatic end_sim();
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(q, x)
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask
	// sleep entry just after an oscillator fall, so no edge races the entry
	task automatic timer_run();
		int k;
		k = 0;
		@(negedge rc);
		apb(1'b1, 8'h60, 32'h1);
		settle();
		`CHK({xen, rfen, clk_o}, 3'b000)
		while (alert_n !== 1'b0 && k < 20) begin
			@(posedge rc);
			k++;
		end
		`CHK(k, 9)
		settle();
		`CHK({alert_n, sda, scl, irq}, 4'b0011)
		rd(8'h64, 32'h2);
		rd(8'h6C, 32'h28);
		m.wake_req();
		m.stop();
		`CHK({alert_n, sda}, 2'b11)
		apb(1'b1, 8'h64, 32'h2);
		settle();
		`CHK(irq, 1'b0)
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(8'h50, 32'h0);
		apb(1'b1, 8'h50, 32'h2);
		apb(1'b1, 8'h54, 32'h3);
		apb(1'b1, 8'h5C, 32'h2);
		apb(1'b1, 8'h68, 32'hF);
		rd(8'h54, 32'h3);
		rd(8'h7C, 32'h0);
		`CHK(e, 1'b1)
		timer_run();
		timer_run();
		apb(1'b1, 8'h68, 32'h0);
		apb(1'b1, 8'h60, 32'h1);
		rf <= 1'b1;
		repeat (30) @(posedge pclk);
		`CHK({alert_n, sda, scl, xen, irq}, 5'b01110)
		rf <= 1'b0;
		rd(8'h64, 32'h1);
		apb(1'b1, 8'h68, 32'h1);
		settle();
		`CHK(irq, 1'b1)
		m.start();
		m.stop();
		`CHK(alert_n, 1'b1)
		apb(1'b1, 8'h64, 32'h1);
		settle();
		`CHK(irq, 1'b0)
		apb(1'b1, 8'h60, 32'h1);
		m.wake_req();
		`CHK(alert_n, 1'b1)
		rd(8'h6C, 32'h38);
		m.start();
		m.stop();
		rd(8'h6C, 32'h31);
		m.start();
		m.xbyte(8'h50, 1'b1, b, ack);
		`CHK(ack, 1'b0)
		m.stop();
		m.start();
		m.xbyte(SERIAL_ADDR_WR, 1'b1, b, ack);
		`CHK(ack, 1'b1)
		m.xbyte(8'h10, 1'b1, b, ack);
		m.xbyte(8'hA5, 1'b1, b, ack);
		`CHK(ack, 1'b1)
		m.stop();
		rd(8'h40, 32'hA5);
		m.start();
		m.xbyte(SERIAL_ADDR_WR, 1'b1, b, ack);
		m.xbyte(8'h10, 1'b1, b, ack);
		m.start();
		m.xbyte(8'h69, 1'b1, b, ack);
		m.xbyte(8'hFF, 1'b0, b, ack);
		`CHK(b, 8'hA5)
		m.xbyte(8'hFF, 1'b1, b, ack);
		`CHK(b, 8'h00)
		m.stop();
		brn <= 1'b0;
		rel <= 1'b0;
		repeat (12) @(posedge pclk);
		apb(1'b1, 8'h44, 32'h3C);
		brn <= 1'b1;
		repeat (10) @(posedge pclk);
		// above brownout but below release: still held, write must be lost
		apb(1'b1, 8'h44, 32'h5A);
		rel <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		end_sim();
	end
endmodule
bind wkhs_wakeup wkhs_wakeup_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.supply_above_brownout(supply_above_brownout),
	.serial_clock_line_in(serial_clock_line_in),
	.serial_clock_line_oe(serial_clock_line_oe),
	.serial_data_line_in(serial_data_line_in), .serial_data_line_oe(serial_data_line_oe),
	.data_alert_n(data_alert_n), .xtal_enable(xtal_enable), .irq(irq));
